// ===== core/iod_io_decoder.sv
/*
 * I/O register space decoder: the low 32 I/O registers with byte,
 * single-bit and skip-test access from the core, plus the data-space
 * alias of the whole I/O space.
 * Assumes the core presents at most one request per cycle on the core
 * clock; port pins are asynchronous, peripheral status is synchronous.
 */
// Function
// - Bit set and clear only at 0x00-0x1F.
// - Skip test on one bit, low range.
// - Writing one clears a flag; zero keeps.
// - Bit operations touch only the addressed bit.
// - I/O path decodes 0x00-0x3F, one byte each.
// - Data-space path sits 0x20 above I/O.
module iod_io_decoder
    import iod_pkg::*;
(
    input wire logic clk,
    input wire logic rstn,
    input wire logic ce,
    input wire iod_req_t req,
    input wire iod_pins_t pins,
    input wire iod_stat_t stat,
    input wire iod_evt_t evt,
    output logic [IOD_REG_W-1:0] rdData_q,
    output logic rdValid_q,
    output logic skip_q,
    output logic skipValid_q,
    output logic [IOD_LOW_REGS-1:0][IOD_REG_W-1:0] regFile_q
);

    localparam int PIN_W = $bits(iod_pins_t);

    // ================================================================
    // Pin synchronisers
    logic [PIN_W-1:0] pinS1_q, pinS2_q, pinS3_q, pinF_q;
    logic [PIN_W-1:0] pinS1_d, pinS2_d, pinS3_d, pinF_d;
    iod_pins_t pinsF;

    always_comb begin
        pinS1_d = pins;
        pinS2_d = pinS1_q;
        pinS3_d = pinS2_q;
        // A level counts only once two late stages agree
        pinF_d = (pinS2_q & ~(pinS2_q ^ pinS3_q))
               | (pinF_q & (pinS2_q ^ pinS3_q));
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            pinS1_q <= '0;
            pinS2_q <= '0;
            pinS3_q <= '0;
            pinF_q <= '0;
        end else if (ce) begin
            pinS1_q <= pinS1_d;
            pinS2_q <= pinS2_d;
            pinS3_q <= pinS3_d;
            pinF_q <= pinF_d;
        end
    end

    assign pinsF = iod_pins_t'(pinF_q);

    // ================================================================
    // Request decode
    logic inSpace, isLow, act, byteWr, bitOp, rdOp, skipOp, selBit;
    logic [IOD_IO_AW-1:0] ioAddr;
    logic [IOD_LOW_AW-1:0] lowIdx;
    logic [IOD_REG_W-1:0] wrMask, wrVal, rdByte;
    logic [IOD_REG_W-1:0] rwCur, w1cCur, roCur, setCur;

    always_comb begin
        case (req.op)
            IOD_OP_LOAD, IOD_OP_STORE: begin
                inSpace = (req.addr >= IOD_DATA_OFFSET)
                       && (req.addr <= IOD_DATA_TOP);
                ioAddr = IOD_IO_AW'(req.addr - IOD_DATA_OFFSET);
            end
            default: begin
                inSpace = req.addr <= IOD_IO_TOP;
                ioAddr = req.addr[IOD_IO_AW-1:0];
            end
        endcase
        isLow = inSpace && (ioAddr <= IOD_BIT_TOP);
        lowIdx = ioAddr[IOD_LOW_AW-1:0];
        act = ce && req.valid && inSpace;
        byteWr = act && (req.op == IOD_OP_IO_WRITE
                      || req.op == IOD_OP_STORE);
        // Bit forms are honoured only in the low half
        bitOp = act && isLow && (req.op == IOD_OP_SET_BIT
                              || req.op == IOD_OP_CLEAR_BIT);
        rdOp = act && (req.op == IOD_OP_IO_READ || req.op == IOD_OP_LOAD);
        skipOp = act && isLow && (req.op == IOD_OP_SKIP_SET
                               || req.op == IOD_OP_SKIP_CLEAR);
        // Bit forms act as a one-bit write, so neighbours are untouched
        if (bitOp) begin
            wrMask = IOD_BIT0 << req.bitSel;
            wrVal = (req.op == IOD_OP_SET_BIT) ? IOD_ONES : IOD_ZERO;
        end else if (byteWr && isLow) begin
            wrMask = IOD_ONES;
            wrVal = req.wdata;
        end else begin
            wrMask = IOD_ZERO;
            wrVal = req.wdata;
        end
        // Upper half lives elsewhere; reads zero here
        rdByte = isLow ? regFile_q[lowIdx] : IOD_ZERO;
        selBit = rdByte[req.bitSel];
        rwCur = iod_wr_mask(lowIdx);
        w1cCur = iod_w1c_mask(lowIdx);
        roCur = iod_ro_mask(lowIdx);
        setCur = iod_set_value(lowIdx, evt);
    end

    // ================================================================
    // Register array
    logic [IOD_LOW_REGS-1:0][IOD_REG_W-1:0] regFile_d;

    for (genvar i = 0; i < IOD_LOW_REGS; i++) begin : g_reg
        localparam logic [IOD_LOW_AW-1:0] IDX = IOD_LOW_AW'(i);
        localparam logic [IOD_REG_W-1:0] RW = iod_wr_mask(IDX);
        localparam logic [IOD_REG_W-1:0] W1C = iod_w1c_mask(IDX);
        localparam logic [IOD_REG_W-1:0] RO = iod_ro_mask(IDX);
        logic [IOD_REG_W-1:0] wm, v;

        always_comb begin
            wm = (lowIdx == IDX) ? wrMask : IOD_ZERO;
            v = (regFile_q[i] & ~(wm & RW)) | (wrVal & wm & RW);
            v = v & ~(wm & wrVal & W1C);
            v = (v & ~RO) | (iod_ro_value(IDX, stat, pinsF) & RO);
            // Set beats a clear arriving in the same cycle
            v = v | (iod_set_value(IDX, evt) & W1C);
            regFile_d[i] = v;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            regFile_q <= '{default: IOD_RESET_BYTE};
        end else if (ce) begin
            regFile_q <= regFile_d;
        end
    end

    // ================================================================
    // Answers to the core
    logic [IOD_REG_W-1:0] rdData_d;
    logic rdValid_d, skip_d, skipValid_d;

    always_comb begin
        rdData_d = rdData_q;
        rdValid_d = 1'b0;
        skip_d = skip_q;
        skipValid_d = 1'b0;
        if (rdOp) begin
            rdData_d = rdByte;
            rdValid_d = 1'b1;
        end
        if (skipOp) begin
            skip_d = selBit == (req.op == IOD_OP_SKIP_SET);
            skipValid_d = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            rdData_q <= IOD_ZERO;
            rdValid_q <= 1'b0;
            skip_q <= 1'b0;
            skipValid_q <= 1'b0;
        end else if (ce) begin
            rdData_q <= rdData_d;
            rdValid_q <= rdValid_d;
            skip_q <= skip_d;
            skipValid_q <= skipValid_d;
        end
    end

    // ================================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);

    a_bit_set_low:
    assert property (bitOp && req.op == IOD_OP_SET_BIT && rwCur[req.bitSel]
        |=> regFile_q[$past(lowIdx)][$past(req.bitSel)])
        else $error("bit set did not land");

    a_bit_clear_low:
    assert property (bitOp && req.op == IOD_OP_CLEAR_BIT
        && rwCur[req.bitSel]
        |=> !regFile_q[$past(lowIdx)][$past(req.bitSel)])
        else $error("bit clear did not land");

    a_skip_result:
    assert property (skipOp |=> skipValid_q
        && (skip_q == ($past(selBit)
            == ($past(req.op) == IOD_OP_SKIP_SET))))
        else $error("skip answer wrong");

    a_flag_w1c:
    assert property (byteWr && isLow |=>
        ((regFile_q[$past(lowIdx)] & $past(w1cCur) & $past(req.wdata)
          & ~$past(setCur)) == IOD_ZERO)
        && (($past(regFile_q[lowIdx]) & $past(w1cCur) & ~$past(req.wdata)
          & ~regFile_q[$past(lowIdx)]) == IOD_ZERO))
        else $error("write-one-to-clear misbehaved");

    a_bit_isolation:
    assert property (bitOp |=>
        (((regFile_q[$past(lowIdx)] ^ $past(regFile_q[lowIdx]))
          & ~$past(wrMask) & ~$past(roCur) & ~$past(w1cCur)) == IOD_ZERO)
        && (($past(regFile_q[lowIdx]) & $past(w1cCur) & ~$past(wrMask)
          & ~regFile_q[$past(lowIdx)]) == IOD_ZERO))
        else $error("bit operation disturbed a neighbour");

    a_io_read_path:
    assert property (rdOp && req.op == IOD_OP_IO_READ |=> rdValid_q
        && (rdData_q == ($past(req.addr) <= {2'b00, IOD_BIT_TOP}
            ? $past(regFile_q[req.addr[IOD_LOW_AW-1:0]]) : IOD_ZERO)))
        else $error("I/O read returned wrong byte");

    a_data_offset:
    assert property (ce && req.valid && req.op == IOD_OP_LOAD
        && req.addr >= IOD_DATA_OFFSET && req.addr <= IOD_DATA_LOW_TOP
        |=> rdValid_q
        && rdData_q == $past(regFile_q[req.addr[IOD_LOW_AW-1:0]]))
        else $error("data-space alias off");

    a_reserved_zero:
    assert property ((regFile_q[IOD_RESERVED_SLOT_4]
        | regFile_q[IOD_RESERVED_SLOT_5] | regFile_q[IOD_RESERVED_SLOT_6]
        | regFile_q[IOD_RESERVED_SLOT_7]) == IOD_ZERO
        && !regFile_q[IOD_PORT_D_OUTPUT][IOD_REG_W-1]
        && !regFile_q[IOD_PORT_D_DIRECTION][IOD_REG_W-1]
        && !regFile_q[IOD_PORT_D_INPUT_LEVELS][IOD_REG_W-1])
        else $error("reserved location not zero");

    a_write_visible:
    assert property (byteWr && isLow |=>
        (regFile_q[$past(lowIdx)] & $past(rwCur))
        == ($past(req.wdata) & $past(rwCur)))
        else $error("written byte not visible next cycle");

    a_refused_bit_op:
    assert property (ce && req.valid && !isLow
        && (req.op == IOD_OP_SET_BIT || req.op == IOD_OP_CLEAR_BIT)
        |=> (regFile_q[$past(lowIdx)] & $past(rwCur))
        == ($past(regFile_q[lowIdx]) & $past(rwCur)))
        else $error("bit operation outside low range took effect");

    a_skip_refused:
    assert property (ce && req.valid && !isLow
        && (req.op == IOD_OP_SKIP_SET || req.op == IOD_OP_SKIP_CLEAR)
        |=> !skipValid_q)
        else $error("skip answered outside low range");

    a_quiet_otherwise:
    assert property (ce && !rdOp && !skipOp |=> !rdValid_q && !skipValid_q)
        else $error("answer pulse without a read or skip");

    a_upper_read_zero:
    assert property (rdOp && !isLow |=> rdData_q == IOD_ZERO)
        else $error("upper half read not zero");

    a_store_window:
    assert property (ce && req.valid && req.op == IOD_OP_STORE
        && req.addr < IOD_DATA_OFFSET
        |=> (regFile_q[$past(lowIdx)] & $past(rwCur))
        == ($past(regFile_q[lowIdx]) & $past(rwCur)))
        else $error("store below the data window landed");

    a_freeze_low_ce:
    assert property (!ce |=> $stable(regFile_q) && $stable(rdData_q)
        && $stable(rdValid_q) && $stable(skip_q) && $stable(skipValid_q))
        else $error("state moved while clock enable was low");

    a_pin_filter:
    assert property (ce |=> ((pinF_q ^ $past(pinS2_q))
        & $past(pinS2_q ~^ pinS3_q)) == '0
        && ((pinF_q ^ $past(pinF_q)) & $past(pinS2_q ^ pinS3_q)) == '0)
        else $error("pin level taken before two stages agreed");

    a_pin_image:
    assert property (ce |=> regFile_q[IOD_PORT_B_INPUT_LEVELS]
        == $past(pinsF.port_b_output))
        else $error("pin image lags the filtered level");

    // Events and clears may meet in one cycle; the event must survive
    for (genvar k = 0; k < IOD_LOW_REGS; k++) begin : g_flag_chk
        localparam logic [IOD_LOW_AW-1:0] KDX = IOD_LOW_AW'(k);
        localparam logic [IOD_REG_W-1:0] KW1C = iod_w1c_mask(KDX);
        logic [IOD_REG_W-1:0] setNow;

        assign setNow = iod_set_value(KDX, evt) & KW1C;

        a_flag_set_wins:
        assert property (ce && setNow != IOD_ZERO
            |=> (regFile_q[k] & $past(setNow)) == $past(setNow))
            else $error("flag event lost");
    end

endmodule

// ===== inc/iod_pkg.sv
/*
 * Shared constants, types and per-address field tables for the I/O
 * register space decoder.
 * Assumes one core clock; peripherals consume the register image and
 * feed status levels and flag events back on the same clock.
 */
package iod_pkg;

    // ================================================================
    // Sizes and address windows
    localparam int IOD_REG_W = 8;
    localparam int IOD_LOW_REGS = 32;
    localparam int IOD_LOW_AW = 5;
    localparam int IOD_IO_AW = 6;
    localparam logic [7:0] IOD_IO_TOP = 8'h3f;
    localparam logic [5:0] IOD_BIT_TOP = 6'h1f;
    localparam logic [7:0] IOD_DATA_OFFSET = 8'h20;
    localparam logic [7:0] IOD_DATA_TOP = 8'h5f;
    localparam logic [7:0] IOD_DATA_LOW_TOP = 8'h3f;
    localparam logic [7:0] IOD_ZERO = 8'h00;
    localparam logic [7:0] IOD_ONES = 8'hff;
    localparam logic [7:0] IOD_BIT0 = 8'h01;
    localparam logic [7:0] IOD_RESET_BYTE = 8'h00;

    // ================================================================
    // Register offsets in I/O space
    localparam logic [4:0] IOD_DIGITAL_INPUT_DISABLE = 5'h01;
    localparam logic [4:0] IOD_BAUD_DIVISOR_HIGH = 5'h02;
    localparam logic [4:0] IOD_SERIAL_FRAME_CONTROL = 5'h03;
    localparam logic [4:0] IOD_RESERVED_SLOT_4 = 5'h04;
    localparam logic [4:0] IOD_RESERVED_SLOT_5 = 5'h05;
    localparam logic [4:0] IOD_RESERVED_SLOT_6 = 5'h06;
    localparam logic [4:0] IOD_RESERVED_SLOT_7 = 5'h07;
    localparam logic [4:0] IOD_COMPARATOR_CONTROL_STATUS = 5'h08;
    localparam logic [4:0] IOD_BAUD_DIVISOR_LOW = 5'h09;
    localparam logic [4:0] IOD_SERIAL_CONTROL_B = 5'h0a;
    localparam logic [4:0] IOD_SERIAL_STATUS_A = 5'h0b;
    localparam logic [4:0] IOD_SERIAL_DATA_BUFFER = 5'h0c;
    localparam logic [4:0] IOD_UNIVERSAL_SERIAL_CONTROL = 5'h0d;
    localparam logic [4:0] IOD_UNIVERSAL_SERIAL_STATUS = 5'h0e;
    localparam logic [4:0] IOD_UNIVERSAL_SERIAL_SHIFT_DATA = 5'h0f;
    localparam logic [4:0] IOD_PORT_D_INPUT_LEVELS = 5'h10;
    localparam logic [4:0] IOD_PORT_D_DIRECTION = 5'h11;
    localparam logic [4:0] IOD_PORT_D_OUTPUT = 5'h12;
    localparam logic [4:0] IOD_SCRATCH_BYTE_0 = 5'h13;
    localparam logic [4:0] IOD_SCRATCH_BYTE_1 = 5'h14;
    localparam logic [4:0] IOD_SCRATCH_BYTE_2 = 5'h15;
    localparam logic [4:0] IOD_PORT_B_INPUT_LEVELS = 5'h16;
    localparam logic [4:0] IOD_PORT_B_DIRECTION = 5'h17;
    localparam logic [4:0] IOD_PORT_B_OUTPUT = 5'h18;
    localparam logic [4:0] IOD_PORT_A_INPUT_LEVELS = 5'h19;
    localparam logic [4:0] IOD_PORT_A_DIRECTION = 5'h1a;

    // ================================================================
    // Operations issued by the core
    typedef enum logic [2:0] {
        IOD_OP_IO_READ = 3'b000,
        IOD_OP_IO_WRITE = 3'b001,
        IOD_OP_LOAD = 3'b010,
        IOD_OP_STORE = 3'b011,
        IOD_OP_SET_BIT = 3'b100,
        IOD_OP_CLEAR_BIT = 3'b101,
        IOD_OP_SKIP_SET = 3'b110,
        IOD_OP_SKIP_CLEAR = 3'b111
    } iod_op_t;

    typedef struct packed {
        logic valid;
        iod_op_t op;
        logic [7:0] addr;
        logic [2:0] bitSel;
        logic [7:0] wdata;
    } iod_req_t;

    typedef struct packed {
        logic acOut;
        logic rxComplete;
        logic dataEmpty;
        logic frameErr;
        logic overrun;
        logic parityErr;
        logic rxBit8;
        logic usiCollision;
    } iod_stat_t;

    typedef struct packed {
        logic acEvent;
        logic txDone;
        logic usiStart;
        logic usiOverflow;
        logic usiStop;
    } iod_evt_t;

    typedef struct packed {
        logic [2:0] portA;
        logic [7:0] port_b_output;
        logic [6:0] port_d_output;
    } iod_pins_t;

    // ================================================================
    // Field tables: software-writable, write-one-to-clear, hardware-driven
    function automatic logic [7:0] iod_wr_mask(input logic [4:0] a);
        case (a)
            IOD_DIGITAL_INPUT_DISABLE: return 8'h03;
            IOD_BAUD_DIVISOR_HIGH: return 8'h0f;
            IOD_SERIAL_FRAME_CONTROL: return 8'h7f;
            IOD_COMPARATOR_CONTROL_STATUS: return 8'hcf;
            IOD_SERIAL_CONTROL_B: return 8'hfd;
            IOD_SERIAL_STATUS_A: return 8'h03;
            IOD_UNIVERSAL_SERIAL_STATUS: return 8'h0f;
            IOD_BAUD_DIVISOR_LOW, IOD_SERIAL_DATA_BUFFER,
            IOD_UNIVERSAL_SERIAL_CONTROL, IOD_UNIVERSAL_SERIAL_SHIFT_DATA,
            IOD_SCRATCH_BYTE_0, IOD_SCRATCH_BYTE_1, IOD_SCRATCH_BYTE_2,
            IOD_PORT_B_DIRECTION, IOD_PORT_B_OUTPUT: return 8'hff;
            IOD_PORT_D_DIRECTION, IOD_PORT_D_OUTPUT: return 8'h7f;
            IOD_PORT_A_DIRECTION: return 8'h07;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] iod_w1c_mask(input logic [4:0] a);
        case (a)
            IOD_COMPARATOR_CONTROL_STATUS: return 8'h10;
            IOD_SERIAL_STATUS_A: return 8'h40;
            IOD_UNIVERSAL_SERIAL_STATUS: return 8'he0;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] iod_ro_mask(input logic [4:0] a);
        case (a)
            IOD_COMPARATOR_CONTROL_STATUS: return 8'h20;
            IOD_SERIAL_CONTROL_B: return 8'h02;
            IOD_SERIAL_STATUS_A: return 8'hbc;
            IOD_UNIVERSAL_SERIAL_STATUS: return 8'h10;
            IOD_PORT_D_INPUT_LEVELS: return 8'h7f;
            IOD_PORT_B_INPUT_LEVELS: return 8'hff;
            IOD_PORT_A_INPUT_LEVELS: return 8'h07;
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] iod_ro_value(input logic [4:0] a,
            input iod_stat_t s, input iod_pins_t p);
        case (a)
            IOD_COMPARATOR_CONTROL_STATUS: return {2'b00, s.acOut, 5'h00};
            IOD_SERIAL_CONTROL_B: return {6'h00, s.rxBit8, 1'b0};
            IOD_SERIAL_STATUS_A: return {s.rxComplete, 1'b0, s.dataEmpty,
                s.frameErr, s.overrun, s.parityErr, 2'b00};
            IOD_UNIVERSAL_SERIAL_STATUS: return {3'h0, s.usiCollision, 4'h0};
            IOD_PORT_D_INPUT_LEVELS: return {1'b0, p.port_d_output};
            IOD_PORT_B_INPUT_LEVELS: return p.port_b_output;
            IOD_PORT_A_INPUT_LEVELS: return {5'h00, p.portA};
            default: return 8'h00;
        endcase
    endfunction

    function automatic logic [7:0] iod_set_value(input logic [4:0] a,
            input iod_evt_t e);
        case (a)
            IOD_COMPARATOR_CONTROL_STATUS: return {3'h0, e.acEvent, 4'h0};
            IOD_SERIAL_STATUS_A: return {1'b0, e.txDone, 6'h00};
            IOD_UNIVERSAL_SERIAL_STATUS:
                return {e.usiStart, e.usiOverflow, e.usiStop, 5'h00};
            default: return 8'h00;
        endcase
    endfunction

endpackage

// ===== tb/iod_core_model.sv
/*
 * Core-side request model for the I/O register space decoder.
 * Assumes calls are made just after a rising clock edge; each send is
 * taken by the decoder at the next rising edge.
 */
module iod_core_model
    import iod_pkg::*;
(
    input wire logic clk,
    output iod_req_t req
);
    timeunit 1ns;
    timeprecision 1ns;

    initial begin
        req = '0;
    end

    // ================================================================
    // Request driving
    // Reserved bits and addresses are only written where a test probes
    // them on purpose; normal traffic keeps them clear.
    task automatic send(input iod_op_t op, input logic [7:0] addr,
            input logic [2:0] bitSel, input logic [7:0] wdata);
        req.valid = 1'b1;
        req.op = op;
        req.addr = addr;
        req.bitSel = bitSel;
        req.wdata = wdata;
        @(posedge clk);
        #1;
    endtask

    // Released address, bit and data lines show inverted junk; op keeps the old value
    task automatic idle();
        req.valid = 1'b0;
        req.addr = ~req.addr;
        req.bitSel = ~req.bitSel;
        req.wdata = ~req.wdata;
        @(posedge clk);
        #1;
    endtask

endmodule

// ===== tb/io_register_space_decoder_bench.sv
/*
 * Self-checking bench for the I/O register space decoder.
 * Assumes the core model in iod_core_model.sv and the design package;
 * the clock is 10 MHz and reset is synchronous, active low.
 */
module io_register_space_decoder_bench
    import iod_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;

    logic clk = 1'b0;
    logic rstn = 1'b0;
    logic ce = 1'b1;
    iod_req_t req;
    iod_pins_t pins = '0;
    iod_stat_t stat = '0;
    iod_evt_t evt = '0;
    logic [7:0] rdData_q;
    logic rdValid_q;
    logic skip_q;
    logic skipValid_q;
    logic [31:0][7:0] regFile_q;
    int errors = 0;
    int checks = 0;

    always #50 clk = ~clk;

    iod_io_decoder DUT (
        .clk(clk), .rstn(rstn), .ce(ce), .req(req), .pins(pins),
        .stat(stat), .evt(evt), .rdData_q(rdData_q),
        .rdValid_q(rdValid_q), .skip_q(skip_q),
        .skipValid_q(skipValid_q), .regFile_q(regFile_q)
    );

    iod_core_model core (.clk(clk), .req(req));

    // ================================================================
    // Helpers
    task automatic check(input logic [7:0] got, input logic [7:0] exp,
            input string what);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("unexpected at %0t: %s got %h exp %h", $time, what,
                got, exp);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic wr(input iod_op_t op, input logic [7:0] a,
            input logic [2:0] b, input logic [7:0] d);
        core.send(op, a, b, d);
        core.idle();
    endtask

    // Read or skip test; answer pulse is due one edge after the request
    task automatic ask(input iod_op_t op, input logic [7:0] a,
            input logic [2:0] b, input logic [7:0] exp);
        int n;
        core.send(op, a, b, 8'h00);
        n = 0;
        while (!(rdValid_q === 1'b1 || skipValid_q === 1'b1) && n < 3) begin
            @(posedge clk);
            #1;
            n++;
        end
        if (n == 3) begin
            errors++;
            $display("unexpected at %0t: no answer", $time);
            end_sim();
        end
        check(8'(n), 8'h00, "answer latency");
        check(op[2] ? {7'h00, skip_q} : rdData_q, exp, "answer value");
        core.idle();
    endtask

    // ================================================================
    // Watchdog
    initial begin
        repeat (20000) @(posedge clk);
        errors++;
        $display("unexpected at %0t: run too long", $time);
        end_sim();
    end

    // ================================================================
    // Tests
    initial begin
        repeat (4) @(posedge clk);
        #1;
        rstn = 1'b1;

        for (int i = 0; i < 64; i++) begin
            ask(IOD_OP_IO_READ, 8'(i), 3'h0, 8'h00);
        end
        $display("test decode done");

        core.send(IOD_OP_IO_WRITE, 8'h13, 3'h0, 8'h5a);
        ask(IOD_OP_IO_READ, 8'h13, 3'h0, 8'h5a);
        check(regFile_q[5'h13], 8'h5a, "register image");
        ask(IOD_OP_LOAD, 8'h33, 3'h0, 8'h5a);
        wr(IOD_OP_STORE, 8'h34, 3'h0, 8'hc3);
        ask(IOD_OP_IO_READ, 8'h14, 3'h0, 8'hc3);
        // Frozen clock enable: the write must not be taken
        ce = 1'b0;
        core.send(IOD_OP_IO_WRITE, 8'h15, 3'h0, 8'h3c);
        ce = 1'b1;
        ask(IOD_OP_IO_READ, 8'h15, 3'h0, 8'h00);
        $display("test paths done");

        wr(IOD_OP_IO_WRITE, 8'h18, 3'h0, 8'h81);
        wr(IOD_OP_SET_BIT, 8'h18, 3'h3, 8'h00);
        ask(IOD_OP_IO_READ, 8'h18, 3'h0, 8'h89);
        wr(IOD_OP_CLEAR_BIT, 8'h18, 3'h7, 8'h00);
        ask(IOD_OP_IO_READ, 8'h18, 3'h0, 8'h09);
        wr(IOD_OP_SET_BIT, 8'h20, 3'h0, 8'h00);
        ask(IOD_OP_IO_READ, 8'h20, 3'h0, 8'h00);
        // Upper address 0x33 shares its low five bits with 0x13
        wr(IOD_OP_SET_BIT, 8'h33, 3'h0, 8'h00);
        ask(IOD_OP_IO_READ, 8'h13, 3'h0, 8'h5a);
        $display("test bit ops done");

        pins.port_b_output = 8'ha5;
        repeat (5) @(posedge clk);
        #1;
        ask(IOD_OP_SKIP_SET, 8'h16, 3'h0, 8'h01);
        ask(IOD_OP_SKIP_SET, 8'h16, 3'h1, 8'h00);
        ask(IOD_OP_SKIP_CLEAR, 8'h16, 3'h1, 8'h01);
        ask(IOD_OP_SKIP_CLEAR, 8'h16, 3'h0, 8'h00);
        ask(IOD_OP_SKIP_SET, 8'h18, 3'h3, 8'h01);
        $display("test skip done");

        evt.acEvent = 1'b1;
        @(posedge clk);
        #1;
        evt.acEvent = 1'b0;
        ask(IOD_OP_IO_READ, 8'h08, 3'h0, 8'h10);
        wr(IOD_OP_IO_WRITE, 8'h08, 3'h0, 8'h00);
        ask(IOD_OP_IO_READ, 8'h08, 3'h0, 8'h10);
        wr(IOD_OP_SET_BIT, 8'h08, 3'h0, 8'h00);
        ask(IOD_OP_IO_READ, 8'h08, 3'h0, 8'h11);
        wr(IOD_OP_CLEAR_BIT, 8'h08, 3'h0, 8'h00);
        ask(IOD_OP_IO_READ, 8'h08, 3'h0, 8'h10);
        wr(IOD_OP_IO_WRITE, 8'h08, 3'h0, 8'h10);
        ask(IOD_OP_IO_READ, 8'h08, 3'h0, 8'h00);
        // Event and clearing write in one cycle: the event wins
        evt.acEvent = 1'b1;
        core.send(IOD_OP_IO_WRITE, 8'h08, 3'h0, 8'h10);
        evt.acEvent = 1'b0;
        ask(IOD_OP_IO_READ, 8'h08, 3'h0, 8'h10);
        wr(IOD_OP_SET_BIT, 8'h08, 3'h4, 8'h00);
        ask(IOD_OP_IO_READ, 8'h08, 3'h0, 8'h00);
        stat.acOut = 1'b1;
        @(posedge clk);
        #1;
        ask(IOD_OP_IO_READ, 8'h08, 3'h0, 8'h20);
        stat.acOut = 1'b0;
        $display("test flags done");

        wr(IOD_OP_IO_WRITE, 8'h05, 3'h0, 8'hff);
        ask(IOD_OP_IO_READ, 8'h05, 3'h0, 8'h00);
        wr(IOD_OP_IO_WRITE, 8'h12, 3'h0, 8'hff);
        ask(IOD_OP_IO_READ, 8'h12, 3'h0, 8'h7f);
        $display("test reserved done");

        rstn = 1'b0;
        @(posedge clk);
        #1;
        rstn = 1'b1;
        ask(IOD_OP_IO_READ, 8'h14, 3'h0, 8'h00);
        $display("test reset done");

        end_sim();
    end

endmodule
